// *** hw/oaalu_pkg.sv ***
// Constants, state and command codes for the operand addressing and arithmetic datapath.
// Assumes a single core clock; shared by the datapath module and its bench.
package oaalu_pkg;

  // ----------------------------------------------------------------------------
  // Internal RAM layout
  // ----------------------------------------------------------------------------
  localparam int unsigned RAM_DEPTH     = 256;
  localparam logic [7:0]  BIT_BYTE_BASE = 8'h20;
  localparam logic [7:0]  SFR_BASE      = 8'h80;

  // ----------------------------------------------------------------------------
  // Special function addresses reached by direct mode
  // ----------------------------------------------------------------------------
  localparam logic [7:0] SFR_STACK = 8'h81;
  localparam logic [7:0] SFR_DPL   = 8'h82;
  localparam logic [7:0] SFR_DPH   = 8'h83;
  localparam logic [7:0] SFR_PSW   = 8'hd0;
  localparam logic [7:0] SFR_ACC   = 8'he0;
  localparam logic [7:0] SFR_B     = 8'hf0;

  // ----------------------------------------------------------------------------
  // Status word bits, reset values and decimal adjust constants
  // ----------------------------------------------------------------------------
  localparam int unsigned PSW_CY  = 7;
  localparam int unsigned PSW_AC  = 6;
  localparam int unsigned PSW_RS1 = 4;
  localparam int unsigned PSW_RS0 = 3;
  localparam int unsigned PSW_OV  = 2;
  localparam int unsigned PSW_P   = 0;
  localparam logic [7:0]  STACK_RESET = 8'h07;
  localparam logic [3:0]  BCD_MAX     = 4'h9;
  localparam logic [8:0]  BCD_ADJ_LO  = 9'h006;
  localparam logic [8:0]  BCD_ADJ_HI  = 9'h060;

  // ----------------------------------------------------------------------------
  // Commands, addressing modes, pointer choices and sequencer states
  // ----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ADD = 4'b0000, OP_ADD_WITH_CARRY_OP = 4'b0001, OP_SUB_WITH_BORROW_OP = 4'b0010, OP_INC = 4'b0011,
    OP_DEC = 4'b0100, OP_INC_EXT_DATA_POINTER = 4'b0101, OP_MUL = 4'b0110, OP_DIV = 4'b0111,
    OP_DA = 4'b1000, OP_MOV_A = 4'b1001, OP_MOV_TO = 4'b1010, OP_BIT_RD = 4'b1011
  } oaalu_op_e;

  typedef enum logic [2:0] {
    MD_DIR = 3'b000, MD_IND = 3'b001, MD_REG = 3'b010, MD_ACC = 3'b011,
    MD_IMM = 3'b100, MD_IDX_EXT_DATA_POINTER = 3'b101, MD_IDX_PC = 3'b110
  } oaalu_mode_e;

  typedef enum logic [1:0] {
    PT_R0 = 2'b00, PT_R1 = 2'b01, PT_STACK = 2'b10, PT_EXT_DATA_POINTER = 2'b11
  } oaalu_ptr_e;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0, ST_WAIT = 1'b1
  } oaalu_state_e;

endpackage

// *** hw/oaalu_core.sv ***
// Operand addressing and arithmetic datapath: internal RAM, register banks, operand
// resolution and the arithmetic group. Assumes one command at a time from the
// sequencer, and an external memory that answers each read with mem_ack.
//
// Behaviour
// - RAM bytes 0 to 31 hold four eight-register banks; one bank active.
// - Bytes 32 to 47 also read as 128 bits, bit 00h lowest.
// - Bank-select bits pick bank base 00h, 08h, 10h or 18h.
// - Direct mode uses an 8-bit address; 80h upward reaches special registers.
// - Indirect mode takes the operand address from a register, internal or external.
// - Eight-bit pointers are bank register zero, register one, or stack pointer.
// - Sixteen-bit indirect addresses come only from the data pointer.
// - Register mode decodes a 3-bit selector to one of eight registers.
// - Register bank is taken from the status word at execution time.
// - Register-specific commands imply accumulator or data pointer, no address byte.
// - Immediate mode takes the constant byte following the opcode.
// - Indexed mode reads program memory only; writes are refused.
// - Indexed address is accumulator plus data pointer or program counter.
// - Add, add with carry, subtract with borrow on all four operand modes.
// - Increment and decrement act on accumulator or any internal byte in place.
// - Data pointer increments as one 16-bit value.
// - Multiply puts product high byte in B, low byte in accumulator.
// - Divide leaves quotient in accumulator and remainder in B.
// - Decimal adjust corrects the accumulator after a packed BCD add.
`timescale 1ns/1ps

module oaalu_core (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Command from the sequencer
  input  wire logic        op_valid,
  input  wire logic [3:0]  op_code,
  input  wire logic [2:0]  op_mode,
  input  wire logic [1:0]  ptr_sel,
  input  wire logic [2:0]  reg_sel,
  input  wire logic [7:0]  dir_addr,
  input  wire logic [7:0]  imm_data,
  input  wire logic [15:0] prog_counter,
  // Program and external data memory
  input  wire logic        mem_ack,
  input  wire logic [7:0]  mem_rdata,
  output logic             ext_rd_q,
  output logic             ext_wr_q,
  output logic [15:0]      ext_addr_q,
  output logic [7:0]       ext_wdata_q,
  output logic             code_rd_q,
  output logic [15:0]      code_addr_q,
  // Architectural state and status
  output logic [7:0]       acc_q,
  output logic [7:0]       b_q,
  output logic [7:0]       cpu_status_word_q,
  output logic [7:0]       stack_ptr_q,
  output logic [15:0]      ext_data_pointer_q,
  output logic             bit_q,
  output logic             busy_q,
  output logic             op_done_q,
  output logic             op_error_q
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  logic [7:0]             ram [oaalu_pkg::RAM_DEPTH];
  oaalu_pkg::oaalu_state_e state_q, state_d;
  logic [3:0]             pend_q, pend_d;
  logic [7:0]             acc_d, b_d, psw_d, sp_d;
  logic [15:0]            ext_data_pointer_d, ext_addr_d, code_addr_d;
  logic [7:0]             ext_wdata_d;
  logic                   ext_rd_d, ext_wr_d, code_rd_d, bit_d, busy_d, done_d, err_d;
  logic                   ram_we;
  logic [7:0]             ram_wa, ram_wd;

  // ----------------------------------------------------------------------------
  // Operand resolution
  // ----------------------------------------------------------------------------
  logic [7:0]  bank_base, reg_addr, ptr_val, loc_addr, sfr_rd, opnd, bit_byte;
  logic        loc_is_sfr;

  always_comb begin
    bank_base = {3'h0, cpu_status_word_q[oaalu_pkg::PSW_RS1], cpu_status_word_q[oaalu_pkg::PSW_RS0],
                 3'h0};
    reg_addr  = bank_base | {5'h00, reg_sel};
    case (ptr_sel)
      oaalu_pkg::PT_R0: ptr_val = ram[bank_base];
      oaalu_pkg::PT_R1: ptr_val = ram[bank_base | 8'h01];
      default:          ptr_val = stack_ptr_q;
    endcase
    case (op_mode)
      oaalu_pkg::MD_DIR: loc_addr = dir_addr;
      oaalu_pkg::MD_IND: loc_addr = ptr_val;
      default:           loc_addr = reg_addr;
    endcase
    loc_is_sfr = (op_mode == oaalu_pkg::MD_DIR) && (dir_addr >= oaalu_pkg::SFR_BASE);
    case (dir_addr)
      oaalu_pkg::SFR_STACK: sfr_rd = stack_ptr_q;
      oaalu_pkg::SFR_DPL:   sfr_rd = ext_data_pointer_q[7:0];
      oaalu_pkg::SFR_DPH:   sfr_rd = ext_data_pointer_q[15:8];
      oaalu_pkg::SFR_PSW:   sfr_rd = cpu_status_word_q;
      oaalu_pkg::SFR_ACC:   sfr_rd = acc_q;
      oaalu_pkg::SFR_B:     sfr_rd = b_q;
      default:              sfr_rd = 8'h00;
    endcase
    if (op_mode == oaalu_pkg::MD_IMM) begin
      opnd = imm_data;
    end else if (op_mode == oaalu_pkg::MD_ACC) begin
      opnd = acc_q;
    end else if (loc_is_sfr) begin
      opnd = sfr_rd;
    end else begin
      opnd = ram[loc_addr];
    end
    bit_byte = oaalu_pkg::BIT_BYTE_BASE | {4'h0, dir_addr[6:3]};
  end

  // ----------------------------------------------------------------------------
  // Execution
  // ----------------------------------------------------------------------------
  logic        exec, wr_loc, cy, ac;
  logic [3:0]  cur_op;
  logic [7:0]  opv, wr_val;
  logic [8:0]  sum9, da9;
  logic [4:0]  nib5;
  logic [15:0] prod;

  always_comb begin
    state_d = state_q;  pend_d = pend_q;
    acc_d = acc_q;  b_d = b_q;  psw_d = cpu_status_word_q;  sp_d = stack_ptr_q;
    ext_data_pointer_d = ext_data_pointer_q;  ext_addr_d = ext_addr_q;  ext_wdata_d = ext_wdata_q;
    code_addr_d = code_addr_q;  bit_d = bit_q;
    ext_rd_d = 1'b0;  ext_wr_d = 1'b0;  code_rd_d = 1'b0;  done_d = 1'b0;  err_d = 1'b0;
    ram_we = 1'b0;  ram_wa = loc_addr;  ram_wd = 8'h00;
    exec = 1'b0;  wr_loc = 1'b0;  wr_val = 8'h00;  cur_op = op_code;  opv = opnd;
    cy = cpu_status_word_q[oaalu_pkg::PSW_CY];  ac = cpu_status_word_q[oaalu_pkg::PSW_AC];
    sum9 = 9'h000;  da9 = 9'h000;  nib5 = 5'h00;  prod = 16'h0000;
    case (state_q)
      oaalu_pkg::ST_IDLE: begin
        if (op_valid) begin
          pend_d = op_code;
          if (op_mode == oaalu_pkg::MD_IDX_EXT_DATA_POINTER || op_mode == oaalu_pkg::MD_IDX_PC) begin
            if (op_code == oaalu_pkg::OP_MOV_A) begin
              code_addr_d = ((op_mode == oaalu_pkg::MD_IDX_PC) ? prog_counter : ext_data_pointer_q)
                            + {8'h00, acc_q};
              code_rd_d   = 1'b1;
              state_d     = oaalu_pkg::ST_WAIT;
            end else begin
              err_d = 1'b1;
            end
          end else if (op_mode == oaalu_pkg::MD_IND && ptr_sel == oaalu_pkg::PT_EXT_DATA_POINTER) begin
            ext_addr_d = ext_data_pointer_q;
            if (op_code == oaalu_pkg::OP_MOV_A) begin
              ext_rd_d = 1'b1;
              state_d  = oaalu_pkg::ST_WAIT;
            end else if (op_code == oaalu_pkg::OP_MOV_TO) begin
              ext_wr_d    = 1'b1;
              ext_wdata_d = acc_q;
              done_d      = 1'b1;
            end else begin
              err_d = 1'b1;
            end
          end else begin
            exec = 1'b1;
          end
        end
      end
      oaalu_pkg::ST_WAIT: begin
        if (mem_ack) begin
          exec    = 1'b1;
          cur_op  = pend_q;
          opv     = mem_rdata;
          state_d = oaalu_pkg::ST_IDLE;
        end
      end
      default: state_d = oaalu_pkg::ST_IDLE;
    endcase

    if (exec) begin
      done_d = 1'b1;
      case (cur_op)
        oaalu_pkg::OP_ADD, oaalu_pkg::OP_ADD_WITH_CARRY_OP: begin
          if (cur_op == oaalu_pkg::OP_ADD) begin
            cy = 1'b0;
          end
          sum9  = {1'b0, acc_q} + {1'b0, opv} + {8'h00, cy};
          nib5  = {1'b0, acc_q[3:0]} + {1'b0, opv[3:0]} + {4'h0, cy};
          acc_d = sum9[7:0];
          psw_d[oaalu_pkg::PSW_CY] = sum9[8];
          psw_d[oaalu_pkg::PSW_AC] = nib5[4];
          psw_d[oaalu_pkg::PSW_OV] = (acc_q[7] == opv[7]) && (sum9[7] != acc_q[7]);
        end
        oaalu_pkg::OP_SUB_WITH_BORROW_OP: begin
          sum9  = {1'b0, acc_q} - {1'b0, opv} - {8'h00, cy};
          nib5  = {1'b0, acc_q[3:0]} - {1'b0, opv[3:0]} - {4'h0, cy};
          acc_d = sum9[7:0];
          psw_d[oaalu_pkg::PSW_CY] = sum9[8];
          psw_d[oaalu_pkg::PSW_AC] = nib5[4];
          psw_d[oaalu_pkg::PSW_OV] = (acc_q[7] != opv[7]) && (sum9[7] != acc_q[7]);
        end
        oaalu_pkg::OP_INC, oaalu_pkg::OP_DEC: begin
          if (op_mode == oaalu_pkg::MD_IMM) begin
            err_d = 1'b1;
          end else begin
            wr_loc = 1'b1;
            wr_val = (cur_op == oaalu_pkg::OP_INC) ? opv + 8'h01 : opv - 8'h01;
          end
        end
        oaalu_pkg::OP_INC_EXT_DATA_POINTER: ext_data_pointer_d = ext_data_pointer_q + 16'h0001;
        oaalu_pkg::OP_MUL: begin
          prod  = {8'h00, acc_q} * {8'h00, b_q};
          b_d   = prod[15:8];
          acc_d = prod[7:0];
          psw_d[oaalu_pkg::PSW_CY] = 1'b0;
          psw_d[oaalu_pkg::PSW_OV] = (prod[15:8] != 8'h00);
        end
        oaalu_pkg::OP_DIV: begin
          psw_d[oaalu_pkg::PSW_CY] = 1'b0;
          psw_d[oaalu_pkg::PSW_OV] = (b_q == 8'h00);
          // A zero divisor leaves both operands untouched; only the overflow flag reports it.
          if (b_q != 8'h00) begin
            acc_d = acc_q / b_q;
            b_d   = acc_q % b_q;
          end
        end
        oaalu_pkg::OP_DA: begin
          da9 = {1'b0, acc_q};
          if (acc_q[3:0] > oaalu_pkg::BCD_MAX || ac) begin
            da9 = da9 + oaalu_pkg::BCD_ADJ_LO;
          end
          if (da9[7:4] > oaalu_pkg::BCD_MAX || cy || da9[8]) begin
            da9 = da9 + oaalu_pkg::BCD_ADJ_HI;
          end
          acc_d = da9[7:0];
          psw_d[oaalu_pkg::PSW_CY] = cy | da9[8];
        end
        oaalu_pkg::OP_MOV_A: acc_d = opv;
        oaalu_pkg::OP_MOV_TO: begin
          if (op_mode == oaalu_pkg::MD_IMM) begin
            err_d = 1'b1;
          end else begin
            wr_loc = 1'b1;
            wr_val = acc_q;
          end
        end
        oaalu_pkg::OP_BIT_RD: bit_d = dir_addr[7] ? 1'b0 : ram[bit_byte][dir_addr[2:0]];
        default: err_d = 1'b1;
      endcase
    end

    // In-place writes never pass through the accumulator unless it is the target.
    if (wr_loc) begin
      if (op_mode == oaalu_pkg::MD_ACC) begin
        acc_d = wr_val;
      end else if (loc_is_sfr) begin
        case (dir_addr)
          oaalu_pkg::SFR_STACK: sp_d = wr_val;
          oaalu_pkg::SFR_DPL:   ext_data_pointer_d[7:0] = wr_val;
          oaalu_pkg::SFR_DPH:   ext_data_pointer_d[15:8] = wr_val;
          oaalu_pkg::SFR_PSW:   psw_d = wr_val;
          oaalu_pkg::SFR_ACC:   acc_d = wr_val;
          oaalu_pkg::SFR_B:     b_d = wr_val;
          default:              ;
        endcase
      end else begin
        ram_we = 1'b1;
        ram_wd = wr_val;
      end
    end
    psw_d[oaalu_pkg::PSW_P] = ^acc_d;
    busy_d = (state_d == oaalu_pkg::ST_WAIT);
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  // The RAM carries no reset: clearing 256 bytes would cost a wide reset tree.
  always_ff @(posedge clock) begin
    if (ram_we) begin
      ram[ram_wa] <= ram_wd;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= oaalu_pkg::ST_IDLE;  pend_q <= 4'h0;
      acc_q <= 8'h00;  b_q <= 8'h00;  cpu_status_word_q <= 8'h00;
      stack_ptr_q <= oaalu_pkg::STACK_RESET;  ext_data_pointer_q <= 16'h0000;
      ext_addr_q <= 16'h0000;  ext_wdata_q <= 8'h00;  code_addr_q <= 16'h0000;
      ext_rd_q <= 1'b0;  ext_wr_q <= 1'b0;  code_rd_q <= 1'b0;  bit_q <= 1'b0;
      busy_q <= 1'b0;  op_done_q <= 1'b0;  op_error_q <= 1'b0;
    end else begin
      state_q <= state_d;  pend_q <= pend_d;
      acc_q <= acc_d;  b_q <= b_d;  cpu_status_word_q <= psw_d;
      stack_ptr_q <= sp_d;  ext_data_pointer_q <= ext_data_pointer_d;
      ext_addr_q <= ext_addr_d;  ext_wdata_q <= ext_wdata_d;  code_addr_q <= code_addr_d;
      ext_rd_q <= ext_rd_d;  ext_wr_q <= ext_wr_d;  code_rd_q <= code_rd_d;  bit_q <= bit_d;
      busy_q <= busy_d;  op_done_q <= done_d;  op_error_q <= err_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  logic issue;
  assign issue = op_valid && (state_q == oaalu_pkg::ST_IDLE);

  sequence s_idx_issue;
    issue && op_code == oaalu_pkg::OP_MOV_A && op_mode == oaalu_pkg::MD_IDX_EXT_DATA_POINTER;
  endsequence
  sequence s_code_fetch;
    code_rd_q && busy_q && code_addr_q == $past(ext_data_pointer_q) + {8'h00, $past(acc_q)};
  endsequence

  a_parity_even: assert property (^{acc_q, cpu_status_word_q[oaalu_pkg::PSW_P]} == 1'b0)
    else $error("parity flag does not even out the accumulator");
  a_idx_addr: assert property (s_idx_issue |=> s_code_fetch)
    else $error("indexed read address wrong");
  a_idx_no_write: assert property (issue && op_code == oaalu_pkg::OP_MOV_TO && op_mode == oaalu_pkg::MD_IDX_PC
    |=> op_error_q && !ext_wr_q && !code_rd_q)
    else $error("indexed write was not refused");
  a_ext_pointer: assert property (issue && op_mode == oaalu_pkg::MD_IND && ptr_sel == oaalu_pkg::PT_EXT_DATA_POINTER
    && op_code == oaalu_pkg::OP_MOV_TO |=> ext_wr_q && ext_addr_q == $past(ext_data_pointer_q))
    else $error("external write not addressed by data pointer");
  a_ext_data_pointer_step: assert property (issue && op_code == oaalu_pkg::OP_INC_EXT_DATA_POINTER
    |=> ext_data_pointer_q == $past(ext_data_pointer_q) + 16'h0001)
    else $error("data pointer did not step by one");
  a_mul_result: assert property (issue && op_code == oaalu_pkg::OP_MUL
    |=> {b_q, acc_q} == {8'h00, $past(b_q)} * {8'h00, $past(acc_q)} && !cpu_status_word_q[oaalu_pkg::PSW_CY])
    else $error("multiply result misplaced");
  a_div_result: assert property (issue && op_code == oaalu_pkg::OP_DIV && b_q != 8'h00
    |=> acc_q == $past(acc_q) / $past(b_q) && b_q == $past(acc_q) % $past(b_q))
    else $error("divide result wrong");
  a_div_zero: assert property (issue && op_code == oaalu_pkg::OP_DIV && b_q == 8'h00
    |=> cpu_status_word_q[oaalu_pkg::PSW_OV] && $stable(acc_q))
    else $error("zero divisor not flagged");
  a_add_imm: assert property (issue && op_code == oaalu_pkg::OP_ADD && op_mode == oaalu_pkg::MD_IMM
    |=> {cpu_status_word_q[oaalu_pkg::PSW_CY], acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(imm_data)})
    else $error("add result or carry wrong");
  sequence s_ext_issue;
    issue && op_code == oaalu_pkg::OP_MOV_A && op_mode == oaalu_pkg::MD_IND && ptr_sel == oaalu_pkg::PT_EXT_DATA_POINTER;
  endsequence
  sequence s_ext_finish;
    ext_rd_q && busy_q ##[1:1000] op_done_q;
  endsequence

  a_ext_done: assert property (s_ext_issue |=> s_ext_finish)
    else $error("external read did not complete");

endmodule  // oaalu_core

// *** sim/oaalu_tb.sv ***
// Self-checking bench for the operand addressing and arithmetic datapath.
// Assumes the oaalu_core ports and codes of oaalu_pkg; internal RAM is written before any read.
`timescale 1ns/1ps

module testbench;
  // ---------------------------------------------------------------------------
  // Design ports
  // ---------------------------------------------------------------------------
  logic        clock;
  logic        rst_b;
  logic        op_valid;
  logic [3:0]  op_code;
  logic [2:0]  op_mode;
  logic [1:0]  ptr_sel;
  logic [2:0]  reg_sel;
  logic [7:0]  dir_addr;
  logic [7:0]  imm_data;
  logic [15:0] prog_counter;
  logic        mem_ack;
  logic [7:0]  mem_rdata;
  logic        ext_rd_q, ext_wr_q, code_rd_q, bit_q, busy_q, op_done_q, op_error_q;
  logic [15:0] ext_addr_q, code_addr_q, ext_data_pointer_q;
  logic [7:0]  ext_wdata_q, acc_q, b_q, cpu_status_word_q, stack_ptr_q;
  logic        last_err;
  int          err_total;
  int          compares;

  oaalu_core i_oaalu_core (.clock(clock), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
    .op_mode(op_mode), .ptr_sel(ptr_sel), .reg_sel(reg_sel), .dir_addr(dir_addr), .imm_data(imm_data),
    .prog_counter(prog_counter), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ext_rd_q(ext_rd_q),
    .ext_wr_q(ext_wr_q), .ext_addr_q(ext_addr_q), .ext_wdata_q(ext_wdata_q), .code_rd_q(code_rd_q),
    .code_addr_q(code_addr_q), .acc_q(acc_q), .b_q(b_q), .cpu_status_word_q(cpu_status_word_q),
    .stack_ptr_q(stack_ptr_q), .ext_data_pointer_q(ext_data_pointer_q), .bit_q(bit_q), .busy_q(busy_q),
    .op_done_q(op_done_q), .op_error_q(op_error_q));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Memory answers every read one cycle later with its low address byte scrambled.
  always @(negedge clock) begin
    mem_ack   <= ext_rd_q | code_rd_q;
    mem_rdata <= (code_rd_q ? code_addr_q[7:0] : ext_addr_q[7:0]) ^ 8'h5a;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One command per call; a slow read is waited for under a bounded count.
  task automatic cmd(input logic [3:0] c, input logic [2:0] m, input logic [7:0] a, input logic [7:0] d);
    int i;
    op_code  = c;
    op_mode  = m;
    dir_addr = a;
    reg_sel  = a[2:0];
    ptr_sel  = a[1:0];
    imm_data = d;
    op_valid = 1'b1;
    @(negedge clock);
    op_valid = 1'b0;
    for (i = 0; i < 40 && op_done_q !== 1'b1 && op_error_q !== 1'b1; i++) @(negedge clock);
    last_err = op_error_q;
  endtask

  task automatic set_a(input logic [7:0] v);
    cmd(oaalu_pkg::OP_MOV_A, oaalu_pkg::MD_IMM, 8'h00, v);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    set_a(v);
    cmd(oaalu_pkg::OP_MOV_TO, oaalu_pkg::MD_DIR, a, 8'h00);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cmd(oaalu_pkg::OP_MOV_A, oaalu_pkg::MD_DIR, a, 8'h00);
    chk({8'h00, acc_q}, {8'h00, exp});
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_add_group();
    set_a(8'h7f);
    cmd(oaalu_pkg::OP_ADD, oaalu_pkg::MD_IMM, 8'h00, 8'h01);
    chk({acc_q, cpu_status_word_q}, 16'h8045);
    cmd(oaalu_pkg::OP_ADD_WITH_CARRY_OP, oaalu_pkg::MD_IMM, 8'h00, 8'h80);
    chk({acc_q, cpu_status_word_q}, 16'h0084);
    cmd(oaalu_pkg::OP_SUB_WITH_BORROW_OP, oaalu_pkg::MD_IMM, 8'h00, 8'h01);
    chk({acc_q, cpu_status_word_q}, 16'hfec1);
  endtask

  task automatic t_banks();
    logic [7:0] b;
    for (b = 0; b < 4; b++) begin
      wr(oaalu_pkg::SFR_PSW, {3'b000, b[1:0], 3'b000});
      chk({14'h0, cpu_status_word_q[4:3]}, {14'h0, b[1:0]});
      set_a(8'ha0 + b);
      cmd(oaalu_pkg::OP_MOV_TO, oaalu_pkg::MD_REG, b + 8'h4, 8'h00);
      set_a(8'h00);
      cmd(oaalu_pkg::OP_ADD, oaalu_pkg::MD_REG, b + 8'h4, 8'h00);
      chk({8'h0, acc_q}, {8'h0, 8'ha0 + b});
      rd(b * 8 + b + 4, 8'ha0 + b);
    end
    wr(oaalu_pkg::SFR_PSW, 8'h00);
  endtask

  task automatic t_indirect();
    wr(8'h01, 8'h3a);
    wr(8'h3a, 8'h00);
    set_a(8'h66);
    cmd(oaalu_pkg::OP_MOV_TO, oaalu_pkg::MD_IND, oaalu_pkg::PT_R1, 8'h00);
    rd(8'h3a, 8'h66);
    wr(8'h07, 8'h5c);
    cmd(oaalu_pkg::OP_MOV_A, oaalu_pkg::MD_IND, oaalu_pkg::PT_STACK, 8'h00);
    chk({8'h0, acc_q}, 16'h005c);
  endtask

  task automatic t_bits();
    wr(8'h20, 8'h81);
    wr(8'h2f, 8'h01);
    cmd(oaalu_pkg::OP_BIT_RD, oaalu_pkg::MD_DIR, 8'h00, 8'h00);
    chk({15'h0, bit_q}, 16'h0001);
    cmd(oaalu_pkg::OP_BIT_RD, oaalu_pkg::MD_DIR, 8'h01, 8'h00);
    chk({15'h0, bit_q}, 16'h0000);
    cmd(oaalu_pkg::OP_BIT_RD, oaalu_pkg::MD_DIR, 8'h78, 8'h00);
    chk({15'h0, bit_q}, 16'h0001);
  endtask

  task automatic t_inc_dec();
    wr(8'h40, 8'hff);
    cmd(oaalu_pkg::OP_INC, oaalu_pkg::MD_DIR, 8'h40, 8'h00);
    chk({8'h0, acc_q}, 16'h00ff);
    rd(8'h40, 8'h00);
    cmd(oaalu_pkg::OP_DEC, oaalu_pkg::MD_ACC, 8'h00, 8'h00);
    chk({8'h0, acc_q}, 16'h00ff);
    wr(oaalu_pkg::SFR_DPL, 8'hff);
    wr(oaalu_pkg::SFR_DPH, 8'h12);
    cmd(oaalu_pkg::OP_INC_EXT_DATA_POINTER, oaalu_pkg::MD_ACC, 8'h00, 8'h00);
    chk(ext_data_pointer_q, 16'h1300);
    cmd(oaalu_pkg::OP_INC, oaalu_pkg::MD_IMM, 8'h00, 8'h00);
    chk({15'h0, last_err}, 16'h0001);
  endtask

  task automatic t_mul_div();
    wr(oaalu_pkg::SFR_B, 8'h50);
    set_a(8'h0a);
    cmd(oaalu_pkg::OP_MUL, oaalu_pkg::MD_ACC, 8'h00, 8'h00);
    chk({b_q, acc_q}, 16'h0320);
    chk({14'h0, cpu_status_word_q[7], cpu_status_word_q[2]}, 16'h0001);
    wr(oaalu_pkg::SFR_B, 8'h10);
    set_a(8'hfb);
    cmd(oaalu_pkg::OP_DIV, oaalu_pkg::MD_ACC, 8'h00, 8'h00);
    chk({b_q, acc_q}, 16'h0b0f);
    wr(oaalu_pkg::SFR_B, 8'h00);
    set_a(8'h33);
    cmd(oaalu_pkg::OP_DIV, oaalu_pkg::MD_ACC, 8'h00, 8'h00);
    chk({b_q, acc_q}, 16'h0033);
    chk({14'h0, cpu_status_word_q[7], cpu_status_word_q[2]}, 16'h0001);
  endtask

  task automatic t_decimal();
    set_a(8'h15);
    cmd(oaalu_pkg::OP_ADD, oaalu_pkg::MD_IMM, 8'h00, 8'h27);
    cmd(oaalu_pkg::OP_DA, oaalu_pkg::MD_ACC, 8'h00, 8'h00);
    chk({8'h0, acc_q}, 16'h0042);
    set_a(8'h99);
    cmd(oaalu_pkg::OP_ADD, oaalu_pkg::MD_IMM, 8'h00, 8'h01);
    cmd(oaalu_pkg::OP_DA, oaalu_pkg::MD_ACC, 8'h00, 8'h00);
    chk({7'h0, cpu_status_word_q[7], acc_q}, 16'h0100);
  endtask

  task automatic t_external();
    wr(oaalu_pkg::SFR_DPL, 8'h34);
    wr(oaalu_pkg::SFR_DPH, 8'h12);
    set_a(8'h77);
    cmd(oaalu_pkg::OP_MOV_TO, oaalu_pkg::MD_IND, oaalu_pkg::PT_EXT_DATA_POINTER, 8'h00);
    chk({ext_wr_q, ext_addr_q[14:0]}, 16'h9234);
    chk({8'h0, ext_wdata_q}, 16'h0077);
    cmd(oaalu_pkg::OP_MOV_A, oaalu_pkg::MD_IND, oaalu_pkg::PT_EXT_DATA_POINTER, 8'h00);
    chk({acc_q, ext_addr_q[7:0]}, 16'h6e34);
    cmd(oaalu_pkg::OP_MOV_A, oaalu_pkg::MD_IDX_EXT_DATA_POINTER, 8'h00, 8'h00);
    chk(code_addr_q, 16'h12a2);
    chk({8'h0, acc_q}, 16'h00f8);
    prog_counter = 16'hfff0;
    cmd(oaalu_pkg::OP_MOV_A, oaalu_pkg::MD_IDX_PC, 8'h00, 8'h00);
    chk({code_addr_q[7:0], acc_q}, 16'he8b2);
    cmd(oaalu_pkg::OP_MOV_TO, oaalu_pkg::MD_IDX_EXT_DATA_POINTER, 8'h00, 8'h00);
    chk({15'h0, last_err}, 16'h0001);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    {rst_b, op_valid, op_code, op_mode, ptr_sel, reg_sel, dir_addr, imm_data, prog_counter} = '0;
    err_total = 0;
    compares  = 0;
    repeat (6) @(negedge clock);
    rst_b = 1'b1;
    chk({stack_ptr_q, acc_q}, {oaalu_pkg::STACK_RESET, 8'h00});
    t_add_group();
    t_banks();
    t_indirect();
    t_bits();
    t_inc_dec();
    t_mul_div();
    t_decimal();
    t_external();
    end_sim();
  end

  // The whole run needs about a hundred cycles; this margin only cuts a hang.
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
endmodule // testbench
